// *** inc/umcsb_consts.vh ***
// Purpose: register offsets, bit positions and reset values of the serial modem/baud block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: definitions only
`ifndef UMCSB_CONSTS_VH
`define UMCSB_CONSTS_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define UMCSB_ADR_DATA 5'h00
`define UMCSB_ADR_IEN 5'h04
`define UMCSB_ADR_LCTL 5'h0C
`define UMCSB_ADR_MCTL 5'h10
`define UMCSB_ADR_LSTAT 5'h14
`define UMCSB_ADR_MSTAT 5'h18
`define UMCSB_ADR_IRQ 5'h1C
// ----------------------------------------
// field positions
// ----------------------------------------
`define UMCSB_IEN_RX 0
`define UMCSB_IEN_TX_HOLDING_EMPTY_FLAG 1
`define UMCSB_IEN_MS 3
`define UMCSB_LCTL_DIVISOR_ACCESS_BIT 7
`define UMCSB_LCTL_BRK 6
`define UMCSB_MC_DTR 0
`define UMCSB_MC_RTS 1
`define UMCSB_MC_UA 2
`define UMCSB_MC_UB 3
`define UMCSB_MC_LOOP 4
`define UMCSB_LS_DR 0
`define UMCSB_LS_TX_HOLDING_EMPTY_FLAG 5
`define UMCSB_LS_TX_ALL_EMPTY_FLAG 6
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define UMCSB_LCTL_RST 8'h03
`define UMCSB_DIV_RST 16'h0001
`define UMCSB_OVS 4'hF
`endif

// *** src/umcsb_top.v ***
// Purpose: transmit status flags, modem control with loopback, modem status, baud generator
// Assumes: wishbone classic slave, 8-bit 8N1 character framing, pins two-flop synchronised
// Notes: one ack per access, answered the cycle after strobe; unmapped reads return zero
// Contract
// - holding-empty bit 5 sets on transfer to shifter, clears on cpu write
// - transmit interrupt while holding-empty set and its enable on
// - transmitter-empty bit 6 set only when holding and shifter both empty
// - line status bit 7 always reads zero
// - dtr pin low while modem control bit 0 set, else high
// - rts, user output a and b follow bits 1..3, set means low
// - loopback holds serial out high, ignores serial in, loops shifter to receiver
// - loopback ignores modem input pins, routes outputs inside, forces output pins high
// - loopback keeps interrupts under enable, modem source from control bits 0..3
// - modem control bits 5 to 7 read zero
// - reading modem status clears all four change flags
// - cts change sets status bit 0, raises modem interrupt when enabled
// - dsr change sets status bit 1, raises modem interrupt when enabled
// - ring low-to-high sets status bit 2, raises modem interrupt when enabled
// - dcd change sets status bit 3, raises modem interrupt when enabled
// - outside loopback bits 4..7 are inverted cts, dsr, ri, dcd pins
// - in loopback bits 4..7 equal rts, dtr, user a, user b control bits
// - baud generator divides clock by divisor 1..65535 giving sixteen-times clock
// - divisor held in low and high byte latches, software loads both
// - writing either divisor latch reloads the baud counter at once
// - divisor latches reachable only with line control bit 7 set
// - reading modem status drops pending modem interrupt
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`include "umcsb_consts.vh"
module umcsb_top (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [4:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    input wire serial_in_pin_i,
    input wire cts_n_i,
    input wire dsr_n_i,
    input wire ri_n_i,
    input wire dcd_n_i,
    output reg serial_out_pin_o,
    output reg dtr_n_o,
    output reg rts_n_o,
    output reg user_output_a_n_o,
    output reg user_output_b_n_o,
    output reg baud_tick_o,
    output reg tx_irq_o,
    output reg rx_irq_o,
    output reg ms_irq_o
);
    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    // one access is taken per strobe; a standing ack blocks a second take
    // writes need byte lane 0, the other three lanes are ignored
    // reads of unmapped offsets return zero and are still acknowledged
    // the divisor access bit steers offsets 0x00 and 0x04:
    //   clear: holding register, receive buffer and interrupt enable
    //   set:   low and high divisor latch
    // line control and modem control are reachable in either setting
    // reset divisor split into its two byte latches
    localparam [15:0] div_rst = `UMCSB_DIV_RST;
    reg [7:0] interrupt_enable;
    reg [7:0] line_ctl;
    reg [7:0] modem_control;
    reg [7:0] div_lo;
    reg [7:0] div_hi;
    wire acc = cyc_i & stb_i & ~ack_o;
    wire wr = acc & we_i & sel_i[0];
    wire rd = acc & ~we_i;
    wire divisor_access_bit = line_ctl[`UMCSB_LCTL_DIVISOR_ACCESS_BIT];
    wire loop = modem_control[`UMCSB_MC_LOOP];
    wire wr_thr = wr & (adr_i == `UMCSB_ADR_DATA) & ~divisor_access_bit;
    wire wr_dll = wr & (adr_i == `UMCSB_ADR_DATA) & divisor_access_bit;
    wire wr_dlm = wr & (adr_i == `UMCSB_ADR_IEN) & divisor_access_bit;
    wire rd_msr = rd & (adr_i == `UMCSB_ADR_MSTAT);
    wire rd_rbr = rd & (adr_i == `UMCSB_ADR_DATA) & ~divisor_access_bit;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // serial in and the four modem inputs come from outside the clock
    // two flops each; only the second stage feeds any logic
    // reset state is the inactive high level of every pin, so a cts, dsr or dcd pin
    // that is already active when reset ends shows up as a change
    // bit order: 4 serial in, 3 dcd, 2 ri, 1 dsr, 0 cts
    reg [4:0] pin_s1;
    reg [4:0] pin_s2;
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1 <= 5'h1F;
            pin_s2 <= 5'h1F;
        end else begin
            pin_s1 <= {serial_in_pin_i, dcd_n_i, ri_n_i, dsr_n_i, cts_n_i};
            pin_s2 <= pin_s1;
        end
    end

    // ----------------------------------------
    // baud generator
    // ----------------------------------------
    reg [15:0] baud_cnt;
    wire [15:0] divisor = {div_hi, div_lo};
    wire baud_pulse = (baud_cnt == 16'h0001) | (baud_cnt == 16'h0000);
    // divisor 1 ticks every clock; divisor 0 treated as 1
    // the counter runs down and reloads from the latches on a tick
    // a write to either latch reloads at once, so a new rate never
    // waits out a long count left from the old one
    // software loads both latches before it relies on the rate
    // tick period equals the divisor in clocks: sixteen ticks per bit
    always @(posedge clk_i) begin
        if (rst_i) begin
            baud_cnt <= `UMCSB_DIV_RST;
        end else if (wr_dll) begin
            baud_cnt <= {div_hi, dat_i[7:0]};
        end else if (wr_dlm) begin
            baud_cnt <= {dat_i[7:0], div_lo};
        end else if (baud_pulse) begin
            baud_cnt <= divisor;
        end else begin
            baud_cnt <= baud_cnt - 16'h0001;
        end
    end

    // ----------------------------------------
    // transmitter: holding register and shifter
    // ----------------------------------------
    // a cpu write fills the holding register and clears holding-empty
    // when the shifter is idle the character moves across next cycle
    // and holding-empty sets again; a write in that same cycle wins,
    // since a new character then sits in the holding register
    // frame is start, eight data bits lsb first, one stop
    // each bit lasts sixteen baud ticks
    // the shifter keeps the line high while idle
    reg [7:0] tx_holding_reg;
    reg tx_holding_empty_flag;
    reg [9:0] tx_shift;
    reg [3:0] tx_bits;
    reg [3:0] tx_ovs;
    reg tx_busy;
    wire tx_line = tx_busy ? tx_shift[0] : 1'b1;
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_holding_reg <= 8'h00;
            tx_holding_empty_flag <= 1'b1;
            tx_shift <= 10'h3FF;
            tx_bits <= 4'h0;
            tx_ovs <= 4'h0;
            tx_busy <= 1'b0;
        end else begin
            if (wr_thr) begin
                tx_holding_reg <= dat_i[7:0];
                tx_holding_empty_flag <= 1'b0;
            end else if (!tx_busy && !tx_holding_empty_flag) begin
                tx_holding_empty_flag <= 1'b1;
            end
            if (!tx_busy && !tx_holding_empty_flag) begin
                tx_shift <= {1'b1, tx_holding_reg, 1'b0};
                tx_bits <= 4'h0;
                tx_ovs <= 4'h0;
                tx_busy <= 1'b1;
            end else if (tx_busy && baud_pulse) begin
                tx_ovs <= tx_ovs + 4'h1;
                if (tx_ovs == `UMCSB_OVS) begin
                    tx_shift <= {1'b1, tx_shift[9:1]};
                    tx_bits <= tx_bits + 4'h1;
                    if (tx_bits == 4'h9) begin
                        tx_busy <= 1'b0;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // receiver: loopback selects internal line
    // ----------------------------------------
    // start is seen low on a tick, checked again mid-bit
    // a start that is high again mid-bit is dropped as noise
    // data bits are taken mid-bit, lsb first
    // the buffer and data ready load at the middle of the stop bit
    // a buffer read in that same cycle loses to the new character
    // no error flags: format bits of line control are not used here
    reg [7:0] rx_shift_reg;
    reg [7:0] rx_buf;
    reg rx_ready;
    reg rx_busy;
    reg [3:0] rx_ovs;
    reg [3:0] rx_bits;
    wire rx_line = loop ? tx_line : pin_s2[4];
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_shift_reg <= 8'h00;
            rx_buf <= 8'h00;
            rx_ready <= 1'b0;
            rx_busy <= 1'b0;
            rx_ovs <= 4'h0;
            rx_bits <= 4'h0;
        end else begin
            if (rd_rbr) begin
                rx_ready <= 1'b0;
            end
            if (baud_pulse) begin
                if (!rx_busy) begin
                    if (!rx_line) begin
                        rx_busy <= 1'b1;
                        rx_ovs <= 4'h0;
                        rx_bits <= 4'h0;
                    end
                end else begin
                    rx_ovs <= rx_ovs + 4'h1;
                    if (rx_ovs == 4'h7) begin
                        rx_bits <= rx_bits + 4'h1;
                        if (rx_bits == 4'h0 && rx_line) begin
                            rx_busy <= 1'b0; // false start
                        end else if (rx_bits == 4'h9) begin
                            rx_busy <= 1'b0;
                            rx_buf <= rx_shift_reg;
                            rx_ready <= 1'b1; // set wins over read clear
                        end else if (rx_bits != 4'h0) begin
                            rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
                        end
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // modem inputs and change flags
    // ----------------------------------------
    // change flags set on any edge of cts, dsr and dcd
    // the ring flag sets only when the ring pin goes back high
    // a status read clears all four; a change in that cycle stays set
    // in loopback the control bits stand in for the four pins
    // active-high view: cts, dsr, ri, dcd
    wire [3:0] pin_act = {~pin_s2[3], ~pin_s2[2], ~pin_s2[1], ~pin_s2[0]};
    wire [3:0] loop_act = {modem_control[`UMCSB_MC_UB], modem_control[`UMCSB_MC_UA],
                           modem_control[`UMCSB_MC_DTR], modem_control[`UMCSB_MC_RTS]};
    wire [3:0] ms_act = loop ? loop_act : pin_act;
    reg [3:0] ms_prev;
    reg [3:0] ms_delta;
    wire [3:0] ms_chg = ms_prev ^ ms_act;
    wire [3:0] ms_set = {ms_chg[3], ms_prev[2] & ~ms_act[2], ms_chg[1], ms_chg[0]};
    always @(posedge clk_i) begin
        if (rst_i) begin
            ms_prev <= 4'h0;
            ms_delta <= 4'h0;
        end else begin
            ms_prev <= ms_act;
            ms_delta <= (rd_msr ? 4'h0 : ms_delta) | ms_set;
        end
    end
    // ri active-high falling equals pin low-to-high
    wire [7:0] msr_val = {ms_act[3], ms_act[2], ms_act[1], ms_act[0], ms_delta};

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            interrupt_enable <= 8'h00;
            line_ctl <= `UMCSB_LCTL_RST;
            modem_control <= 8'h00;
            div_lo <= div_rst[7:0];
            div_hi <= div_rst[15:8];
        end else begin
            if (wr_dll) begin
                div_lo <= dat_i[7:0];
            end
            if (wr_dlm) begin
                div_hi <= dat_i[7:0];
            end
            if (wr & (adr_i == `UMCSB_ADR_IEN) & ~divisor_access_bit) begin
                interrupt_enable <= {4'h0, dat_i[3:0]};
            end
            if (wr & (adr_i == `UMCSB_ADR_LCTL)) begin
                line_ctl <= dat_i[7:0];
            end
            if (wr & (adr_i == `UMCSB_ADR_MCTL)) begin
                modem_control <= {3'h0, dat_i[4:0]};
            end
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    // all registers are eight bits wide in byte lane 0
    // line status: bit 0 data ready, 5 holding empty, 6 all empty
    // line status bits 1 to 4 and 7 read zero
    // modem control keeps only its low five bits
    // irq status at 0x1C: bit 0 rx, bit 1 tx, bit 2 modem
    wire tx_all_empty_flag = tx_holding_empty_flag & ~tx_busy;
    wire [7:0] lsr_val = {1'b0, tx_all_empty_flag, tx_holding_empty_flag, 4'h0, rx_ready};
    reg [7:0] rd_val;
    always @* begin
        case (adr_i)
            `UMCSB_ADR_DATA: rd_val = divisor_access_bit ? div_lo : rx_buf;
            `UMCSB_ADR_IEN: rd_val = divisor_access_bit ? div_hi : interrupt_enable;
            `UMCSB_ADR_LCTL: rd_val = line_ctl;
            `UMCSB_ADR_MCTL: rd_val = modem_control;
            `UMCSB_ADR_LSTAT: rd_val = lsr_val;
            `UMCSB_ADR_MSTAT: rd_val = msr_val;
            `UMCSB_ADR_IRQ: rd_val = {5'h00, ms_irq_o, tx_irq_o, rx_irq_o};
            default: rd_val = 8'h00;
        endcase
    end

    // ----------------------------------------
    // bus answer, pins and interrupt requests
    // ----------------------------------------
    // every output comes straight from a flop
    // ack is one cycle; read data stands in the ack cycle only
    // loopback forces serial out and the four control pins high
    // break pulls serial out low outside loopback
    // modem interrupt drops in the cycle of a status read
    // tx interrupt drops in the cycle of a holding write
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
            serial_out_pin_o <= 1'b1;
            dtr_n_o <= 1'b1;
            rts_n_o <= 1'b1;
            user_output_a_n_o <= 1'b1;
            user_output_b_n_o <= 1'b1;
            baud_tick_o <= 1'b0;
            tx_irq_o <= 1'b0;
            rx_irq_o <= 1'b0;
            ms_irq_o <= 1'b0;
        end else begin
            ack_o <= acc;
            dat_o <= rd ? {24'h000000, rd_val} : 32'h00000000;
            serial_out_pin_o <= loop | (tx_line & ~line_ctl[`UMCSB_LCTL_BRK]);
            dtr_n_o <= loop | ~modem_control[`UMCSB_MC_DTR];
            rts_n_o <= loop | ~modem_control[`UMCSB_MC_RTS];
            user_output_a_n_o <= loop | ~modem_control[`UMCSB_MC_UA];
            user_output_b_n_o <= loop | ~modem_control[`UMCSB_MC_UB];
            baud_tick_o <= baud_pulse;
            tx_irq_o <= tx_holding_empty_flag & ~wr_thr & interrupt_enable[`UMCSB_IEN_TX_HOLDING_EMPTY_FLAG];
            rx_irq_o <= rx_ready & interrupt_enable[`UMCSB_IEN_RX];
            ms_irq_o <= (|((rd_msr ? 4'h0 : ms_delta) | ms_set)) & interrupt_enable[`UMCSB_IEN_MS];
        end
    end
endmodule

// *** verification/testbench.sv ***
// Purpose: self-checking bench for the modem, status and baud block
// Assumes: data set model on the modem lines
// Notes: table of register accesses, then hand tests
`timescale 1ns/10ps
`include "umcsb_consts.vh"
module testbench;
    localparam [4:0] a_dat = `UMCSB_ADR_DATA, a_mct = `UMCSB_ADR_MCTL;
    localparam [4:0] a_lst = `UMCSB_ADR_LSTAT, a_mst = `UMCSB_ADR_MSTAT;
    reg clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    reg ring = 1'b0, carrier = 1'b0, line = 1'b1;
    reg [4:0] adr_i = 5'h00;
    reg [3:0] sel_i = 4'hF;
    reg [31:0] dat_i = 32'h0;
    reg [7:0] q;
    reg [13:0] rows [0:11];
    wire [31:0] dat_o;
    wire ack_o, serial_in_pin_i, cts_n_i, dsr_n_i, ri_n_i, dcd_n_i, serial_out_pin_o, tx_irq_o, ms_irq_o;
    wire dtr_n_o, rts_n_o, user_output_a_n_o, user_output_b_n_o, rx_irq_o;
    wire [7:0] pins = {user_output_b_n_o, user_output_a_n_o, rts_n_o, dtr_n_o, 3'h0, serial_out_pin_o};
    integer fail_count = 0, checked = 0, i;
    // ----
    // clock, device and data set
    // ----
    always #5 clk_i = ~clk_i;
    umcsb_top umcsb_top_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .serial_in_pin_i, .cts_n_i, .dsr_n_i, .ri_n_i, .dcd_n_i, .serial_out_pin_o, .dtr_n_o, .rts_n_o,
        .user_output_a_n_o, .user_output_b_n_o, .baud_tick_o(), .tx_irq_o, .rx_irq_o, .ms_irq_o);
    umcsb_modem umcsb_modem_inst (.clk_i, .dtr_n_i(dtr_n_o), .rts_n_i(rts_n_o), .ring_i(ring),
        .carrier_i(carrier), .line_i(line), .cts_n_o(cts_n_i), .dsr_n_o(dsr_n_i), .ri_n_o(ri_n_i),
        .dcd_n_o(dcd_n_i), .serial_in_pin_o(serial_in_pin_i));
    // ----
    // tasks
    // ----
    task stop_test;
        begin
            $display("checked %0d mismatches %0d", checked, fail_count);
            if (fail_count == 0 && checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task cmp(input [7:0] got, input [7:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wt(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    task bus(input w, input [4:0] a, input [7:0] d);
        integer n;
        begin
            n = 0;
            cyc_i <= 1'b1;
            stb_i <= 1'b1;
            we_i <= w;
            adr_i <= a;
            dat_i <= {24'h0, d};
            @(posedge clk_i);
            while (ack_o !== 1'b1) begin
                @(posedge clk_i);
                n = n + 1;
                if (n > 20) begin
                    fail_count = fail_count + 1;
                    stop_test;
                end
            end
            q = dat_o[7:0];
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    task rd(input [4:0] a, input [7:0] exp);
        begin
            bus(1'b0, a, 8'h00);
            cmp(q, exp);
        end
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        rows[0] = {1'b0, a_lst, 8'h60};
        rows[1] = {1'b1, a_mct, 8'hEF};
        rows[2] = {1'b0, a_mct, 8'h0F};
        rows[3] = {1'b0, 5'h08, 8'h00};
        rows[4] = {1'b1, 5'h0C, 8'h83};
        rows[5] = {1'b1, a_dat, 8'h03};
        rows[6] = {1'b1, 5'h04, 8'h00};
        rows[7] = {1'b0, a_dat, 8'h03};
        rows[8] = {1'b1, 5'h0C, 8'h03};
        rows[9] = {1'b0, 5'h0C, 8'h03};
        rows[10] = {1'b1, 5'h04, 8'h0A};
        rows[11] = {1'b0, 5'h04, 8'h0A};
        wt(5);
        rst_i <= 1'b0;
        for (i = 0; i < 12; i = i + 1) begin
            if (rows[i][13])
                bus(1'b1, rows[i][12:8], rows[i][7:0]);
            else
                rd(rows[i][12:8], rows[i][7:0]);
        end
        for (i = 0; i < 4; i = i + 1) begin
            bus(1'b1, a_mct, 8'h01 << i);
            wt(2);
            cmp(pins, {4'hF ^ (4'h1 << i), 4'h1});
        end
        $display("test registers and pins done");
        bus(1'b1, a_mct, 8'h03);
        wt(12);
        cmp({tx_irq_o, ms_irq_o}, 8'h03);
        rd(a_mst, 8'h33);
        rd(a_mst, 8'h30);
        cmp({7'h0, ms_irq_o}, 8'h00);
        ring <= 1'b1;
        wt(8);
        rd(a_mst, 8'h70);
        ring <= 1'b0;
        wt(8);
        cmp({7'h0, ms_irq_o}, 8'h01);
        rd(a_mst, 8'h34);
        carrier <= 1'b1;
        wt(8);
        rd(a_mst, 8'hB8);
        $display("test modem status done");
        bus(1'b1, a_mct, 8'h15);
        line <= 1'b0;
        wt(8);
        rd(a_mst, 8'h69);
        cmp(pins, 8'hF1);
        bus(1'b1, a_dat, 8'hA5);
        rd(a_lst, 8'h20);
        bus(1'b1, a_dat, 8'h3C);
        rd(a_lst, 8'h00);
        cmp({7'h0, tx_irq_o}, 8'h00);
        for (i = 0; i < 1000 && q[6] !== 1'b1; i = i + 1)
            bus(1'b0, a_lst, 8'h00);
        if (i == 1000) begin
            fail_count = fail_count + 1;
            stop_test;
        end
        wt(50);
        cmp({7'h0, tx_irq_o}, 8'h01);
        rd(a_lst, 8'h61);
        bus(1'b1, 5'h04, 8'h0B);
        cmp({7'h0, rx_irq_o}, 8'h01);
        rd(a_dat, 8'h3C);
        cmp({7'h0, rx_irq_o}, 8'h00);
        $display("test loopback done");
        rst_i <= 1'b1;
        wt(5);
        rst_i <= 1'b0;
        wt(1);
        cmp(pins, 8'hF1);
        rd(a_mct, 8'h00);
        rd(a_lst, 8'h60);
        $display("test reset done");
        stop_test;
    end
endmodule

// *** verification/umcsb_modem.sv ***
// Purpose: data set model on the modem and serial lines
// Assumes: answers dtr with dsr and rts with cts
// Notes: ring, carrier and serial level come from the bench
`timescale 1ns/10ps
module umcsb_modem #(
    parameter DELAY = 4
) (
    input wire clk_i,
    input wire dtr_n_i,
    input wire rts_n_i,
    input wire ring_i,
    input wire carrier_i,
    input wire line_i,
    output reg cts_n_o = 1'b1,
    output reg dsr_n_o = 1'b1,
    output wire ri_n_o,
    output wire dcd_n_o,
    output wire serial_in_pin_o
);
    reg [7:0] dtr_d = 8'hFF;
    reg [7:0] rts_d = 8'hFF;
    // ring and carrier are active low on the wire
    assign ri_n_o = ~ring_i;
    assign dcd_n_o = ~carrier_i;
    assign serial_in_pin_o = line_i;
    // answer the terminal handshake after DELAY+1 clocks
    always @(posedge clk_i) begin
        dtr_d <= {dtr_d[6:0], dtr_n_i};
        rts_d <= {rts_d[6:0], rts_n_i};
        dsr_n_o <= dtr_d[DELAY-1];
        cts_n_o <= rts_d[DELAY-1];
    end
endmodule

// *** verification/umcsb_props.sv ***
// Purpose: port checker for the modem, status and baud block
// Assumes: classic wishbone, registers in byte lane 0
// Notes: shadows written registers from observed bus writes
`timescale 1ns/10ps
`include "umcsb_consts.vh"
module umcsb_props (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [4:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    input wire serial_out_pin_o,
    input wire dtr_n_o,
    input wire rts_n_o,
    input wire user_output_a_n_o,
    input wire user_output_b_n_o,
    input wire baud_tick_o,
    input wire tx_irq_o,
    input wire ms_irq_o
);
    reg [7:0] mc, lc;
    reg [15:0] div, cnt;
    reg [4:0] radr;
    reg armed, ien_tx;
    wire take = cyc_i & stb_i & ~ack_o;
    wire wr = take & we_i & sel_i[0];
    wire lo = adr_i == `UMCSB_ADR_DATA;
    wire hi = adr_i == `UMCSB_ADR_IEN;
    wire wr_div = wr & lc[7] & (lo | hi);
    wire [3:0] pins = {user_output_b_n_o, user_output_a_n_o, rts_n_o, dtr_n_o};
    wire [15:0] gap = (div == 16'h0000) ? 16'h0000 : div - 16'h0001;
    // ----
    // shadow registers, read address and tick spacing
    // ----
    always @(posedge clk_i) begin
        cnt <= baud_tick_o ? 16'h0000 : cnt + 16'h0001;
        radr <= (take && !we_i) ? adr_i : 5'h1F;
        if (rst_i) begin
            mc <= 8'h00;
            lc <= `UMCSB_LCTL_RST;
            div <= `UMCSB_DIV_RST;
            ien_tx <= 1'b0;
            armed <= 1'b0;
        end else begin
            armed <= wr_div ? 1'b0 : (armed | baud_tick_o);
            if (wr && adr_i == `UMCSB_ADR_MCTL) mc <= dat_i[7:0];
            if (wr && adr_i == `UMCSB_ADR_LCTL) lc <= dat_i[7:0];
            if (wr && !lc[7] && hi) ien_tx <= dat_i[`UMCSB_IEN_TX_HOLDING_EMPTY_FLAG];
            if (wr_div && lo) div[7:0] <= dat_i[7:0];
            if (wr_div && hi) div[15:8] <= dat_i[7:0];
        end
    end
    // ----
    // properties
    // ----
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    lsr_top_a: assert property (ack_o && radr == `UMCSB_ADR_LSTAT |-> !dat_o[7])
        else $error("line status bit 7 set");
    mctl_high_a: assert property (ack_o && radr == `UMCSB_ADR_MCTL |-> dat_o[7:5] == 3'h0)
        else $error("modem control upper bits set");
    pins_follow_a: assert property (!mc[4] && mc == $past(mc) |-> pins == ~mc[3:0])
        else $error("modem pins differ from control");
    loop_pins_a: assert property (mc[4] && $past(mc[4]) |-> pins == 4'hF)
        else $error("modem pins not high in loopback");
    loop_serial_out_pin_a: assert property (mc[4] && $past(mc[4]) |-> serial_out_pin_o)
        else $error("serial out low in loopback");
    ms_read_a: assert property (ack_o && radr == `UMCSB_ADR_MSTAT |-> !ms_irq_o)
        else $error("modem irq kept after status read");
    tx_off_a: assert property (!ien_tx && !$past(ien_tx) |-> !tx_irq_o)
        else $error("tx irq while disabled");
    baud_gap_a: assert property (armed && baud_tick_o |-> cnt == gap)
        else $error("baud tick spacing wrong");
    baud_reload_a: assert property (wr_div ##1 div <= 16'h0003 |-> ##[0:4] baud_tick_o)
        else $error("no tick soon after divisor load");
endmodule
bind umcsb_top umcsb_props umcsb_props_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .serial_out_pin_o, .dtr_n_o, .rts_n_o, .user_output_a_n_o, .user_output_b_n_o,
    .baud_tick_o, .tx_irq_o, .ms_irq_o);
